// ### src/mst_pkg.sv
// constants, field layout and types shared by the supervision block
package mst_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERR = 8'h08;
  localparam logic [7:0] ADDR_VEQ = 8'h0C;
  localparam logic [7:0] ADDR_ENERGY = 8'h10;
  // control fields
  localparam int CTRL_SENS_LSB = 0;
  localparam int CTRL_NOM_LSB = 2;
  localparam int CTRL_NO_LOAD_THRESHOLD_SELECT_LSB = 4;
  localparam int CTRL_TAMPER_FACTOR_SELECT_BIT = 6;
  localparam int CTRL_WIDTH = 7;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 7'h00;
  // status fields
  localparam int ST_BFR = 0;
  localparam int ST_NOLOAD = 1;
  localparam int ST_SWM = 2;
  localparam int ST_TAMPER = 3;
  localparam int ST_SEC_HIGH = 4;
  localparam int ST_CHSEL = 5;
  // sticky error fields
  localparam int ERR_STUCK_V = 0;
  localparam int ERR_STUCK_I = 1;
  localparam int ERR_PIN = 2;
  localparam int ERR_WIDTH = 3;
  // sensor select codes below this value mean coil sensor
  localparam logic [1:0] SENS_COIL_LIMIT = 2'h2;
  // nominal voltage coefficients, unsigned Q0.16
  localparam logic [15:0] NOM_COEFF [4] = '{16'h5C01, 16'h63FE, 16'h6C02, 16'h73FF};
  // no-load base thresholds, product of two Q0.16 rms values
  localparam logic [31:0] NOLOAD_BASE_COIL = 32'h01262025;
  localparam logic [31:0] NOLOAD_BASE_CT = 32'h00EF1281;
  // low-voltage error set levels, Q0.16; cleared above twice
  localparam logic [15:0] BFR_ON_COIL = 16'h0273;
  localparam logic [15:0] BFR_ON_CT = 16'h01FF;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINE_NOM_NS = 20_000_000;
  localparam int LINE_NOM_CYC = LINE_NOM_NS / CLK_PERIOD_NS;
  localparam int PERIOD_LOW_LIMIT_CYC = 131072;
  localparam int PERIOD_HIGH_LIMIT_CYC = 32768;
  localparam logic [1:0] OVER_REPEAT = 2'h3;
  localparam logic [6:0] SD_WINDOW_CYC = 7'h7F;
  // tamper multiplex frame, in line periods
  localparam logic [6:0] SW_NORMAL = 7'h20;
  localparam logic [6:0] SW_PRI = 7'h3C;
  localparam logic [6:0] SW_SEC = 7'h04;
  localparam logic [6:0] EVAL_HALF = 7'h04;
  localparam logic [2:0] QUAL_COUNT = 3'h4;
  localparam int SD_STREAMS = 2;
  typedef enum logic [1:0] {TS_NORMAL, TS_PRI, TS_SEC} mst_tstate_type;
endpackage

// ### src/mst_sd_if.sv
// carrier between the top and the sigma-delta stream checker
`timescale 1ns/1ps
interface mst_sd_if;
  import mst_pkg::*;
  logic [SD_STREAMS-1:0] raw;
  logic [SD_STREAMS-1:0] stuck;
  logic [SD_STREAMS-1:0] clean;
  modport chk (input raw, output stuck, output clean);
  modport top (output raw, input stuck, input clean);
endinterface

// ### src/mst_sdchk.sv
// stuck detection and idle substitution for the sigma-delta streams
`timescale 1ns/1ps
module mst_sdchk import mst_pkg::*; (
  input wire logic CLK,
  input wire logic RESETN,
  mst_sd_if.chk sd
);
  genvar g;
  generate
    for (g = 0; g < SD_STREAMS; g++) begin : g_stream
      logic s1_r, s2_r, s3_r, idle_r, stuck_r, clean_r;
      logic [6:0] run_r;
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end else begin
          s1_r <= sd.raw[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          run_r <= 7'h00;
          stuck_r <= 1'b0;
        end else if (s2_r != s3_r) begin
          run_r <= 7'h00;
          stuck_r <= 1'b0;
        end else if (run_r != SD_WINDOW_CYC) begin
          run_r <= run_r + 7'h01;
        end else begin
          stuck_r <= 1'b1;
        end
      end
      always_ff @(posedge CLK) begin
        if (!RESETN) begin
          idle_r <= 1'b0;
          clean_r <= 1'b0;
        end else begin
          idle_r <= !idle_r;
          clean_r <= stuck_r ? idle_r : s2_r;
        end
      end
      assign sd.stuck[g] = stuck_r;
      assign sd.clean[g] = clean_r;
      a_idle_toggles: assert property (@(posedge CLK) disable iff (!RESETN)
        stuck_r ##1 stuck_r |=> (clean_r != $past(clean_r)))
        else $error("idle stream does not alternate while stuck");
    end
  endgenerate
endmodule // mst_sdchk

// ### src/mst_top.sv
// supervision top: fallback energy, no-load, error checks and tamper state machine
`timescale 1ns/1ps
module mst_top import mst_pkg::*; #(
  parameter int unsigned PERIOD_LOW_LIMIT = PERIOD_LOW_LIMIT_CYC,
  parameter int unsigned PERIOD_HIGH_LIMIT = PERIOD_HIGH_LIMIT_CYC,
  parameter int unsigned LINE_NOM_PERIOD = LINE_NOM_CYC
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] FULL_SCALE_PEAK_LINE,
  input wire logic [15:0] VRMS,
  input wire logic [15:0] IRMS,
  input wire logic PEAK_STROBE,
  input wire logic [31:0] CH_ENERGY,
  input wire logic CH_ENERGY_VALID,
  input wire logic SD_V_IN,
  input wire logic SD_I_IN,
  input wire logic STEP_POS_DRV,
  input wire logic STEP_NEG_DRV,
  input wire logic ENERGY_PULSE_DRV,
  input wire logic STEP_POS_SENSE,
  input wire logic STEP_NEG_SENSE,
  input wire logic ENERGY_PULSE_SENSE,
  output logic SD_V_CLEAN,
  output logic SD_I_CLEAN,
  output logic CH_SELECT_SEC,
  output logic [32:0] ENERGY_INC,
  output logic ENERGY_VALID,
  output logic POWER_INTEGRATE_EN,
  output logic SINGLE_WIRE_OPERATION,
  output logic STEPPER_OUT_POS,
  output logic STEPPER_OUT_NEG,
  output logic ENERGY_PULSE_OUT,
  output logic NO_LOAD_INDICATOR_PIN,
  output logic TAMPER_OUTPUT_PIN
);
  function automatic logic addr_mapped(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_ERR) || (a == ADDR_VEQ) || (a == ADDR_ENERGY);
  endfunction

  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [ERR_WIDTH-1:0] err_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, rdata_w;
  logic lo_err_r, hi_err_r, v_low_r, no_load_r, swm_r, integ_r;
  logic [1:0] over_r;
  logic [22:0] per_cnt_r, swm_cnt_r;
  logic swm_tick_r;
  logic [15:0] veq_r;
  logic [5:0] pos_r;
  logic signed [35:0] acc_a_r, acc_b_r;
  logic eval_r, last_opp_r, ch_sel_r, energy_valid_r, nl_pin_r, tpin_r;
  logic [32:0] energy_r, hold_r;
  logic [2:0] qcnt_r;
  mst_tstate_type tstate_r, qcand_r;
  logic [2:0] out_r, out_d1_r, out_d2_r, sense_s1_r, sense_s2_r;
  mst_sd_if sd_bus ();

  logic [1:0] sens, nominal_voltage_select, no_load_threshold_select;
  logic tamper_factor_select_sel, coil, base_freq_error_flag, single_wire_operation, stuck_any, disable_w, tick, no_load_nxt, gate_nxt;
  logic [15:0] bfr_on, v_used;
  logic [31:0] veq_prod, pw, app, thr;
  logic signed [32:0] e;
  logic [6:0] sw, pos7;
  logic in_a, in_b, cur_sec, opp, a_hi, tamper_factor_select, mismatch_w, wr_en, tamper_w;
  logic [35:0] abs_a, abs_b, abs_sum;
  logic [36:0] abs_diff;
  logic signed [36:0] diff, sum;
  mst_tstate_type cand;

  assign sens = ctrl_r[CTRL_SENS_LSB +: 2];
  assign nominal_voltage_select = ctrl_r[CTRL_NOM_LSB +: 2];
  assign no_load_threshold_select = ctrl_r[CTRL_NO_LOAD_THRESHOLD_SELECT_LSB +: 2];
  assign tamper_factor_select_sel = ctrl_r[CTRL_TAMPER_FACTOR_SELECT_BIT];
  assign coil = sens < SENS_COIL_LIMIT;
  assign base_freq_error_flag = lo_err_r || hi_err_r || v_low_r;
  assign single_wire_operation = coil && base_freq_error_flag;
  assign stuck_any = |sd_bus.stuck;
  assign disable_w = (base_freq_error_flag && !single_wire_operation) || stuck_any || no_load_r;
  assign sd_bus.raw = {SD_I_IN, SD_V_IN};
  mst_sdchk mst_sdchk_inst (.CLK(CLK), .RESETN(RESETN), .sd(sd_bus.chk));
  assign SD_V_CLEAN = sd_bus.clean[0];
  assign SD_I_CLEAN = sd_bus.clean[1];

  // APB slave, one wait state on every access
  assign wr_en = PSEL && PENABLE && pready_r && PWRITE;
  always_comb begin
    rdata_w = 32'h00000000;
    case (PADDR)
      ADDR_CTRL: rdata_w[CTRL_WIDTH-1:0] = ctrl_r;
      ADDR_STATUS: begin
        rdata_w[ST_BFR] = base_freq_error_flag;
        rdata_w[ST_NOLOAD] = no_load_r;
        rdata_w[ST_SWM] = swm_r;
        rdata_w[ST_TAMPER] = tamper_w;
        rdata_w[ST_SEC_HIGH] = tstate_r == TS_SEC;
        rdata_w[ST_CHSEL] = ch_sel_r;
      end
      ADDR_ERR: rdata_w[ERR_WIDTH-1:0] = err_r;
      ADDR_VEQ: rdata_w[15:0] = veq_r;
      ADDR_ENERGY: rdata_w = energy_r[31:0];
      default: rdata_w = 32'h00000000;
    endcase
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= PSEL && PENABLE && !pready_r;
      pslverr_r <= PSEL && PENABLE && !pready_r && !addr_mapped(PADDR);
      prdata_r <= (PSEL && PENABLE && !pready_r && !PWRITE) ? rdata_w : 32'h00000000;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_en && PADDR == ADDR_CTRL) begin
      ctrl_r <= PWDATA[CTRL_WIDTH-1:0];
    end
  end
  // pin readback error, set beats clear
  assign mismatch_w = sense_s2_r != out_d2_r;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      err_r <= '0;
    end else begin
      err_r <= (err_r & ~((wr_en && PADDR == ADDR_ERR) ? PWDATA[ERR_WIDTH-1:0] : 3'h0))
        | {mismatch_w, sd_bus.stuck[1], sd_bus.stuck[0]};
    end
  end

  // period limits; three short periods in a row needed
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      per_cnt_r <= '0;
      over_r <= 2'h0;
      lo_err_r <= 1'b0;
      hi_err_r <= 1'b0;
    end else if (PEAK_STROBE) begin
      per_cnt_r <= '0;
      lo_err_r <= 1'b0;
      if (per_cnt_r < 23'(PERIOD_HIGH_LIMIT)) begin
        over_r <= (over_r == OVER_REPEAT) ? over_r : over_r + 2'h1;
        hi_err_r <= hi_err_r || (over_r == OVER_REPEAT - 2'h1);
      end else begin
        over_r <= 2'h0;
        hi_err_r <= 1'b0;
      end
    end else if (per_cnt_r < 23'(PERIOD_LOW_LIMIT)) begin
      per_cnt_r <= per_cnt_r + 23'h1;
    end else begin
      lo_err_r <= 1'b1;
    end
  end
  assign bfr_on = coil ? BFR_ON_COIL : BFR_ON_CT;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      v_low_r <= 1'b0;
    end else if (VRMS < bfr_on) begin
      v_low_r <= 1'b1;
    end else if (VRMS > {bfr_on[14:0], 1'b0}) begin
      v_low_r <= 1'b0;
    end
  end

  assign veq_prod = FULL_SCALE_PEAK_LINE * NOM_COEFF[nominal_voltage_select];
  // measured voltage again once the error clears
  assign v_used = single_wire_operation ? veq_r : VRMS;
  assign pw = v_used * IRMS;
  assign app = IRMS * veq_r;
  assign thr = (coil ? NOLOAD_BASE_COIL : NOLOAD_BASE_CT) << no_load_threshold_select;
  assign no_load_nxt = pw < thr;
  assign gate_nxt = !base_freq_error_flag || single_wire_operation;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      veq_r <= 16'h0000;
      no_load_r <= 1'b0;
      nl_pin_r <= 1'b1;
      swm_r <= 1'b0;
      integ_r <= 1'b0;
    end else begin
      veq_r <= veq_prod[31:16];
      no_load_r <= no_load_nxt;
      nl_pin_r <= !no_load_nxt;
      swm_r <= single_wire_operation;
      integ_r <= !no_load_nxt && gate_nxt && !stuck_any;
    end
  end
  // no voltage peaks in single-wire, so periods come from a nominal timer
  always_ff @(posedge CLK) begin
    if (!RESETN || !single_wire_operation) begin
      swm_cnt_r <= '0;
      swm_tick_r <= 1'b0;
    end else begin
      swm_tick_r <= swm_cnt_r == 23'(LINE_NOM_PERIOD - 1);
      swm_cnt_r <= (swm_cnt_r == 23'(LINE_NOM_PERIOD - 1)) ? '0 : swm_cnt_r + 23'h1;
    end
  end
  assign tick = single_wire_operation ? swm_tick_r : CH_ENERGY_VALID;
  assign e = single_wire_operation ? $signed({1'b0, app}) : $signed({CH_ENERGY[31], CH_ENERGY});

  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      out_r <= 3'h0;
      out_d1_r <= 3'h0;
      out_d2_r <= 3'h0;
      sense_s1_r <= 3'h0;
      sense_s2_r <= 3'h0;
    end else begin
      out_r <= {ENERGY_PULSE_DRV && gate_nxt, STEP_NEG_DRV && gate_nxt && !no_load_nxt,
        STEP_POS_DRV && gate_nxt && !no_load_nxt};
      out_d1_r <= out_r;
      out_d2_r <= out_d1_r;
      sense_s1_r <= {ENERGY_PULSE_SENSE, STEP_NEG_SENSE, STEP_POS_SENSE};
      sense_s2_r <= sense_s1_r;
    end
  end

  always_comb begin
    case (tstate_r)
      TS_PRI: sw = SW_PRI;
      TS_SEC: sw = SW_SEC;
      default: sw = SW_NORMAL;
    endcase
  end
  assign pos7 = {1'b0, pos_r};
  // four periods either side of the switch
  assign in_a = (pos7 >= sw - EVAL_HALF) && (pos7 < sw);
  assign in_b = (pos7 >= sw) && (pos7 < sw + EVAL_HALF);
  assign cur_sec = pos7 >= sw;
  always_ff @(posedge CLK) begin
    if (!RESETN || disable_w) begin
      pos_r <= 6'h00;
      acc_a_r <= '0;
      acc_b_r <= '0;
      eval_r <= 1'b0;
    end else begin
      eval_r <= tick && (pos7 == sw + EVAL_HALF - 7'h01);
      if (tick) begin
        pos_r <= pos_r + 6'h01;
        if (pos7 == sw - EVAL_HALF) begin
          acc_a_r <= 36'(e);
        end else if (in_a) begin
          acc_a_r <= acc_a_r + 36'(e);
        end
        if (pos7 == sw) begin
          acc_b_r <= 36'(e);
        end else if (in_b) begin
          acc_b_r <= acc_b_r + 36'(e);
        end
      end
    end
  end

  assign diff = 37'(acc_a_r) - 37'(acc_b_r);
  assign sum = 37'(acc_a_r) + 37'(acc_b_r);
  assign abs_diff = diff[36] ? 37'(-diff) : 37'(diff);
  assign abs_sum = sum[36] ? 36'(-sum) : 36'(sum);
  assign abs_a = acc_a_r[35] ? 36'(-acc_a_r) : 36'(acc_a_r);
  assign abs_b = acc_b_r[35] ? 36'(-acc_b_r) : 36'(acc_b_r);
  assign tamper_factor_select = tamper_factor_select_sel ? ({abs_diff, 5'h00} > 42'(abs_sum)) : ({abs_diff, 4'h0} > 41'(abs_sum));
  assign opp = (acc_a_r[35] != acc_b_r[35]) && (acc_a_r != '0) && (acc_b_r != '0);
  assign a_hi = abs_a > abs_b;
  assign cand = (opp || tamper_factor_select) ? (a_hi ? TS_PRI : TS_SEC) : TS_NORMAL;
  assign tamper_w = tstate_r != TS_NORMAL;

  // four consecutive results move the state; one opposite-sign result moves it at once
  always_ff @(posedge CLK) begin
    if (!RESETN || disable_w) begin
      tstate_r <= TS_NORMAL;
      qcand_r <= TS_NORMAL;
      qcnt_r <= 3'h0;
      last_opp_r <= 1'b0;
    end else if (eval_r) begin
      last_opp_r <= opp;
      if (opp) begin
        tstate_r <= cand;
        qcnt_r <= 3'h0;
      end else if (cand == tstate_r) begin
        qcnt_r <= 3'h0;
      end else if (cand == qcand_r && qcnt_r == QUAL_COUNT - 3'h1) begin
        tstate_r <= cand;
        qcnt_r <= 3'h0;
      end else if (cand == qcand_r) begin
        qcnt_r <= qcnt_r + 3'h1;
      end else begin
        qcand_r <= cand;
        qcnt_r <= 3'h1;
      end
    end
  end

  // hold last favoured value through the gap
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      energy_r <= '0;
      hold_r <= '0;
      energy_valid_r <= 1'b0;
      ch_sel_r <= 1'b0;
      tpin_r <= 1'b1;
    end else begin
      ch_sel_r <= cur_sec;
      tpin_r <= !tamper_w;
      energy_valid_r <= tick && integ_r;
      if (tick) begin
        if (!tamper_w || (cur_sec == (tstate_r == TS_SEC))) begin
          energy_r <= e;
          hold_r <= e;
        end else begin
          energy_r <= hold_r;
        end
      end
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign CH_SELECT_SEC = ch_sel_r;
  assign ENERGY_INC = energy_r;
  assign ENERGY_VALID = energy_valid_r;
  assign POWER_INTEGRATE_EN = integ_r;
  assign SINGLE_WIRE_OPERATION = swm_r;
  assign STEPPER_OUT_POS = out_r[0];
  assign STEPPER_OUT_NEG = out_r[1];
  assign ENERGY_PULSE_OUT = out_r[2];
  assign NO_LOAD_INDICATOR_PIN = nl_pin_r;
  assign TAMPER_OUTPUT_PIN = tpin_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_quiet_eval;
    !disable_w && eval_r && !opp;
  endsequence
  sequence s_enter;
    !tamper_w ##1 tamper_w;
  endsequence
  a_noload_pins: assert property (no_load_r |-> !NO_LOAD_INDICATOR_PIN && !STEPPER_OUT_POS && !STEPPER_OUT_NEG)
    else $error("no-load did not block stepper or indicator");
  a_noload_integ: assert property (no_load_r |-> !POWER_INTEGRATE_EN ##1 tstate_r == TS_NORMAL)
    else $error("no-load did not suspend integration or tamper");
  a_tamper_pin: assert property (1'b1 |=> TAMPER_OUTPUT_PIN == !$past(tamper_w))
    else $error("tamper pin does not follow state");
  a_disable_normal: assert property (disable_w |=> tstate_r == TS_NORMAL && qcnt_r == 3'h0)
    else $error("tamper not forced normal when disabled");
  a_swm_enter: assert property (base_freq_error_flag && coil |=> SINGLE_WIRE_OPERATION)
    else $error("single-wire not entered");
  a_bfr_hold: assert property (base_freq_error_flag && !coil |=> !STEPPER_OUT_POS && !STEPPER_OUT_NEG && !ENERGY_PULSE_OUT)
    else $error("outputs not held low on frequency error");
  a_entry_qual: assert property (s_enter |-> last_opp_r || $past(qcnt_r) == QUAL_COUNT - 3'h1)
    else $error("tamper entered without qualification");
  a_noentry_early: assert property (s_quiet_eval ##0 (qcnt_r < QUAL_COUNT - 3'h2) ##0 !tamper_w |=> !tamper_w)
    else $error("tamper entered too early");
  a_err_sticky: assert property (mismatch_w |=> err_r[ERR_PIN] [*2])
    else $error("pin mismatch not recorded");
endmodule // mst_top

// ### testbench/mst_top_test.sv
// self-checking bench for the supervision block
`timescale 1ns/1ps
module mst_top_test;
  import mst_pkg::*;
  logic clk = 0;
  logic rstn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, b;
  logic [15:0] vrms = 16'h8000;
  logic [15:0] irms = 16'h4000;
  logic [15:0] full_scale_peak_line = 16'h8000;
  logic epd = 1'b1;
  logic pk = 0, cv = 0, sdv = 0, sdi = 0, hold = 0;
  logic [31:0] ce = 32'h0;
  logic signed [31:0] ea = 1000, eb = 1000;
  logic [2:0] frc = 3'h0;
  logic sdvc, sdic, sec, ev, pie, swo, sp, sn, ep, nlp, tp;
  logic [32:0] einc;
  int cyc = 0, ns = 0, s0, k, bad_count = 0, check_count = 0;

  // short counts keep line periods to a hundred clocks
  mst_top #(.PERIOD_LOW_LIMIT(200), .PERIOD_HIGH_LIMIT(50), .LINE_NOM_PERIOD(100)) mst_top_inst (
    .CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .FULL_SCALE_PEAK_LINE(full_scale_peak_line), .VRMS(vrms), .IRMS(irms), .PEAK_STROBE(pk), .CH_ENERGY(ce),
    .CH_ENERGY_VALID(cv), .SD_V_IN(sdv), .SD_I_IN(sdi), .STEP_POS_DRV(1'b1), .STEP_NEG_DRV(1'b1),
    .ENERGY_PULSE_DRV(epd), .STEP_POS_SENSE(sp ^ frc[0]), .STEP_NEG_SENSE(sn ^ frc[1]),
    .ENERGY_PULSE_SENSE(ep ^ frc[2]), .SD_V_CLEAN(sdvc), .SD_I_CLEAN(sdic), .CH_SELECT_SEC(sec),
    .ENERGY_INC(einc), .ENERGY_VALID(ev), .POWER_INTEGRATE_EN(pie), .SINGLE_WIRE_OPERATION(swo),
    .STEPPER_OUT_POS(sp), .STEPPER_OUT_NEG(sn), .ENERGY_PULSE_OUT(ep), .NO_LOAD_INDICATOR_PIN(nlp),
    .TAMPER_OUTPUT_PIN(tp));

  initial begin
    forever #2 clk = ~clk;
  end

  // energy follows the channel the block selects; pins read back what it drives
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pk <= (cyc % 100) == 0;
    cv <= (cyc % 4) == 0;
    ce <= sec ? eb : ea;
    sdv <= ~sdv;
    sdi <= hold ? sdi : ~sdi;
    if (cv && sec) ns <= ns + 1;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) bad_count++;
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    chk(33'(q & m), 33'(x));
  endtask

  task automatic wt_tp(input logic lvl, input int lim);
    for (int n = 0; n < lim && tp !== lvl; n++)
      @(posedge clk);
  endtask

  task automatic tally_and_finish;
    if (bad_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end

  initial begin
    repeat (2) @(posedge clk);
    chk(33'({nlp, tp, pie}), 33'h6);
    rstn <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk({e, q}, 33'h100000000);
    repeat (300) @(posedge clk);
    chk(33'({pie, nlp, tp}), 33'h7);
    rd(ADDR_STATUS, 32'h1F, 32'h0);
    s0 = ns;
    repeat (512) @(posedge clk);
    chk(33'(ns - s0), 33'h40);
    // a tenth apart: only the finer factor sees it
    eb <= 900;
    repeat (1536) @(posedge clk);
    chk(33'(tp), 33'h1);
    wr(ADDR_CTRL, 32'h40);
    repeat (512) @(posedge clk);
    chk(33'(tp), 33'h1);
    wt_tp(1'b0, 2000);
    chk(33'(tp), 33'h0);
    rd(ADDR_STATUS, 32'h18, 32'h8);
    repeat (256) @(posedge clk);
    s0 = ns;
    repeat (512) @(posedge clk);
    chk(33'(ns - s0), 33'h8);
    rd(ADDR_ENERGY, 32'hFFFFFFFF, 32'h3E8);
    eb <= 1000;
    repeat (512) @(posedge clk);
    chk(33'(tp), 33'h0);
    wt_tp(1'b1, 2000);
    chk(33'(tp), 33'h1);
    eb <= -1000;
    wt_tp(1'b0, 400);
    chk(33'(tp), 33'h0);
    eb <= 1000;
    irms <= 16'h0200;
    repeat (10) @(posedge clk);
    chk(33'({tp, nlp, pie, sp}), 33'h8);
    rd(ADDR_STATUS, 32'h2, 32'h2);
    // each threshold straddled by one current step
    for (k = 0; k < 4; k++) begin
      wr(ADDR_CTRL, 32'(k << 4));
      irms <= 16'h024C << k;
      repeat (8) @(posedge clk);
      rd(ADDR_STATUS, 32'h2, 32'h2);
      irms <= 16'h024D << k;
      repeat (8) @(posedge clk);
      rd(ADDR_STATUS, 32'h2, 32'h0);
    end
    irms <= 16'h4000;
    for (k = 0; k < 4; k++) begin
      // peak reading halves each step, so the product scaling is exercised too
      full_scale_peak_line <= 16'h8000 >> k;
      wr(ADDR_CTRL, 32'(k << 2));
      rd(ADDR_VEQ, 32'hFFFF, 32'(NOM_COEFF[k] >> (k + 1)));
    end
    vrms <= 16'h0100;
    repeat (10) @(posedge clk);
    rd(ADDR_STATUS, 32'h5, 32'h5);
    chk(33'(swo), 33'h1);
    // two nominal-timer periods so the apparent energy has been latched
    repeat (220) @(posedge clk);
    rd(ADDR_ENERGY, 32'hFFFFFFFF, (32'(NOM_COEFF[3]) >> 4) << 14);
    wr(ADDR_CTRL, 32'h2);
    repeat (4) @(posedge clk);
    rd(ADDR_STATUS, 32'h5, 32'h1);
    chk(33'({sp, sn, ep}), 33'h0);
    wr(ADDR_CTRL, 32'h0);
    vrms <= 16'h8000;
    repeat (10) @(posedge clk);
    chk(33'(swo), 33'h0);
    rd(ADDR_ENERGY, 32'hFFFFFFFF, 32'h3E8);
    epd <= 1'b0;
    repeat (4) @(posedge clk);
    chk(33'({ep, sp}), 33'h1);
    epd <= 1'b1;
    hold <= 1'b1;
    repeat (200) @(posedge clk);
    rd(ADDR_ERR, 32'h7, 32'h2);
    chk(33'(pie), 33'h0);
    b = sdic;
    @(posedge clk);
    chk(33'(sdic ^ b), 33'h1);
    hold <= 1'b0;
    repeat (8) @(posedge clk);
    wr(ADDR_ERR, 32'h2);
    rd(ADDR_ERR, 32'h7, 32'h0);
    frc <= 3'h1;
    repeat (10) @(posedge clk);
    rd(ADDR_ERR, 32'h7, 32'h4);
    frc <= 3'h0;
    repeat (8) @(posedge clk);
    wr(ADDR_ERR, 32'h4);
    rd(ADDR_ERR, 32'h7, 32'h0);
    tally_and_finish;
  end
endmodule // mst_top_test
